// >>> hdl/scr_pkg.sv
// shared constants and types of the system control register block
package scr_pkg;

    // register indices; the apb byte address is four times the index
    localparam int unsigned ADDR_W          = 14;
    localparam logic [11:0] IDX_UNLOCK_KEY  = 12'h040;
    localparam logic [11:0] IDX_CHIP_ID     = 12'h041;
    localparam logic [11:0] IDX_UNLOCK_ID   = 12'h042;
    localparam logic [11:0] IDX_WDOG_COUNT  = 12'h043;
    localparam logic [11:0] IDX_RESET_CAUSE = 12'h044;
    localparam logic [11:0] IDX_BOOT_CFG    = 12'h045;
    localparam logic [11:0] IDX_RESET_CTRL  = 12'h048;

    // unlock key values
    localparam logic [7:0] KEY_FIRST  = 8'h57;
    localparam logic [7:0] KEY_SECOND = 8'ha8;

    // timing: one system clock is one tsys
    localparam int unsigned UNLOCK_TIME_TSYS = 16;
    localparam int unsigned TSYS_PER_CYCLE   = 1;
    localparam int unsigned UNLOCK_CYCLES    = UNLOCK_TIME_TSYS / TSYS_PER_CYCLE;
    localparam int unsigned WDOG_TICK_TSYS   = 131072;
    localparam int unsigned WDOG_TICK_CYCLES = WDOG_TICK_TSYS / TSYS_PER_CYCLE;
    localparam int unsigned WDOG_PRE_W       = 17;

    // field positions
    localparam int unsigned KEY_TIMER_LSB     = 4;
    localparam int unsigned KEY_ACT_BIT       = 3;
    localparam int unsigned CAUSE_CODE_OFS    = 4;
    localparam int unsigned CFG_BOOT_BIT      = 5;
    localparam int unsigned CFG_DEBUG_BIT     = 4;
    localparam int unsigned CFG_BOOT_EN_BIT   = 3;
    localparam int unsigned CFG_MRST_EN_BIT   = 2;
    localparam int unsigned CFG_ROM_READ_BIT  = 0;
    localparam int unsigned CTRL_WDOG_RST_BIT = 1;
    localparam int unsigned CTRL_SW_RST_BIT   = 0;

    // reset values and codes
    localparam logic [1:0] CFG_RSVD_HI = 2'b11;
    localparam logic [2:0] CAUSE_SR    = 3'b000;
    localparam logic [2:0] CAUSE_POR   = 3'b001;
    localparam logic [2:0] CAUSE_WTR   = 3'b010;
    localparam logic [2:0] CAUSE_MR    = 3'b011;
    localparam logic [2:0] CAUSE_SHUTDOWN_WAKE_GLOBAL_RESET = 3'b101;
    localparam logic [2:0] CAUSE_LRW   = 3'b100;

    typedef enum logic [1:0] {
        UNL_LOCKED = 2'b00,
        UNL_KEY1   = 2'b01,
        UNL_OPEN   = 2'b11
    } scr_unlock_t;

    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } scr_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } scr_apb_rsp_t;

    typedef struct packed {
        logic in_boot_program;
        logic debug_port_enabled;
        logic boot_program_enabled;
        logic manual_reset_pin_enabled;
        logic flash_readout_allowed;
    } scr_straps_t;

    typedef struct packed {
        logic manual_pin_reset;
        logic shutdown_wake_global_reset;
        logic sleep_wake_local_reset;
    } scr_reset_evt_t;

    typedef struct packed {
        scr_unlock_t           unlock;
        logic [3:0]            win_cnt;
        logic [7:0]            wdog_cnt;
        logic [WDOG_PRE_W-1:0] wdog_pre;
        logic                  wdog_rst_en;
        logic                  code_base;
        logic [2:0]            cause;
        scr_straps_t           strap_m;
        scr_straps_t           strap_s;
        logic [31:0]           rdata;
        logic                  slverr;
        logic                  sys_rst_req;
    } scr_state_t;

    localparam scr_state_t STATE_RST = '{
        unlock: UNL_LOCKED, win_cnt: 4'h0, wdog_cnt: 8'h00, wdog_pre: '0,
        wdog_rst_en: 1'b0, code_base: 1'b0, cause: CAUSE_POR,
        strap_m: '0, strap_s: '0, rdata: 32'h0000_0000, slverr: 1'b0,
        sys_rst_req: 1'b0};

endpackage

// >>> hdl/scr_system_control_regs.sv
// system control registers: unlock window, watchdog counter, reset cause, boot status
`timescale 1ns/10ps
module scr_system_control_regs #(
    parameter logic [7:0]  CHIP_ID_CODE     = 8'h5a,                    // arbitrary value
    parameter logic [7:0]  UNLOCK_ID_CODE   = 8'h3c,                    // arbitrary value
    parameter int unsigned WDOG_TICK_CYCLES = scr_pkg::WDOG_TICK_CYCLES // shorten for simulation
) (
    input  wire logic                   sys_clk_in,            // system clock, 125 mhz
    input  wire logic                   rst_n_in,              // power-on reset, active low
    input  wire scr_pkg::scr_apb_req_t  apb_req_in,            // apb request
    output scr_pkg::scr_apb_rsp_t       apb_rsp_out,           // apb response
    input  wire scr_pkg::scr_reset_evt_t reset_evt_in,         // reset event pulses
    input  wire scr_pkg::scr_straps_t   straps_in,             // configuration straps, async
    output logic                        unlocked_out,          // guarded writes allowed
    output logic                        code_base_select_out,  // 1: code starts at 0x008000
    output logic [2:0]                  last_reset_cause_out,  // recorded reset cause
    output logic                        sys_reset_req_out      // pulse: request system reset
);

    logic [1:0]          rst_sync_r;
    logic                rst_n;
    scr_pkg::scr_state_t state_r;
    scr_pkg::scr_state_t state_nxt;
    logic                wr_acc;
    logic                rd_setup;
    logic [11:0]         idx;
    logic                aligned;
    logic                guard_ok;
    logic                key_wr;
    logic                wdog_tick;
    logic                wdog_ovf;
    logic                sw_req;

    // decode a register hit from the word index, rejecting unaligned bytes
    function automatic logic hit(input logic [11:0] i, input logic [11:0] target, input logic al);
        hit = al && (i == target);
    endfunction

    // volatile state returns to its reset value; the watchdog reset enable stays when keep is set
    function automatic scr_pkg::scr_state_t warm(input scr_pkg::scr_state_t s, input logic keep);
        scr_pkg::scr_state_t w;
        w          = s;
        w.unlock   = scr_pkg::UNL_LOCKED;
        w.win_cnt  = 4'h0;
        w.wdog_cnt = 8'h00;
        w.wdog_pre = '0;
        if (!keep) begin
            w.wdog_rst_en = 1'b0;
        end
        warm = w;
    endfunction

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    assign idx      = apb_req_in.paddr[scr_pkg::ADDR_W-1:2];
    assign aligned  = (apb_req_in.paddr[1:0] == 2'b00);
    // writes land on the access edge; pready is always high so every access lasts one cycle
    assign wr_acc   = apb_req_in.psel && apb_req_in.penable && apb_req_in.pwrite;
    assign rd_setup = apb_req_in.psel && !apb_req_in.penable;
    assign guard_ok = (state_r.unlock == scr_pkg::UNL_OPEN);
    assign key_wr   = wr_acc && hit(idx, scr_pkg::IDX_UNLOCK_KEY, aligned);
    assign wdog_tick = (state_r.wdog_pre == scr_pkg::WDOG_PRE_W'(WDOG_TICK_CYCLES - 1));
    assign wdog_ovf  = wdog_tick && (state_r.wdog_cnt == 8'hff)
                       && !(wr_acc && hit(idx, scr_pkg::IDX_WDOG_COUNT, aligned));
    assign sw_req    = wr_acc && guard_ok && hit(idx, scr_pkg::IDX_RESET_CTRL, aligned)
                       && apb_req_in.pwdata[scr_pkg::CTRL_SW_RST_BIT];

    always_comb begin
        state_nxt             = state_r;
        state_nxt.sys_rst_req = 1'b0;
        state_nxt.strap_m     = straps_in;
        state_nxt.strap_s     = state_r.strap_m;

        // unlock window timer; reaching the limit locks again with no software help
        if (state_r.unlock == scr_pkg::UNL_OPEN) begin
            if (state_r.win_cnt == 4'(scr_pkg::UNLOCK_CYCLES - 1)) begin
                state_nxt.unlock  = scr_pkg::UNL_LOCKED;
                state_nxt.win_cnt = 4'h0;
            end else begin
                state_nxt.win_cnt = state_r.win_cnt + 4'h1;
            end
        end

        // key sequence; a 0x57 always arms the first step again
        if (key_wr) begin
            state_nxt.win_cnt = 4'h0;
            unique case (state_r.unlock)
                scr_pkg::UNL_LOCKED: begin
                    state_nxt.unlock = (apb_req_in.pwdata[7:0] == scr_pkg::KEY_FIRST) ?
                                       scr_pkg::UNL_KEY1 : scr_pkg::UNL_LOCKED;
                end
                scr_pkg::UNL_KEY1: begin
                    if (apb_req_in.pwdata[7:0] == scr_pkg::KEY_SECOND) begin
                        state_nxt.unlock = scr_pkg::UNL_OPEN;
                    end else if (apb_req_in.pwdata[7:0] == scr_pkg::KEY_FIRST) begin
                        state_nxt.unlock = scr_pkg::UNL_KEY1;
                    end else begin
                        state_nxt.unlock = scr_pkg::UNL_LOCKED;
                    end
                end
                scr_pkg::UNL_OPEN: begin
                    state_nxt.unlock = (apb_req_in.pwdata[7:0] == scr_pkg::KEY_FIRST) ?
                                       scr_pkg::UNL_KEY1 : scr_pkg::UNL_LOCKED;
                end
                default: begin
                    state_nxt.unlock = scr_pkg::UNL_LOCKED;
                end
            endcase
        end

        // watchdog prescaler and counter; a preset beats a tick in the same cycle
        state_nxt.wdog_pre = wdog_tick ? '0 : state_r.wdog_pre + 1'b1;
        if (wr_acc && hit(idx, scr_pkg::IDX_WDOG_COUNT, aligned)) begin
            state_nxt.wdog_cnt = apb_req_in.pwdata[7:0];
        end else if (wdog_tick) begin
            state_nxt.wdog_cnt = state_r.wdog_cnt + 8'h01;
        end

        // guarded writes; a locked write is dropped silently and still completes on the bus
        if (wr_acc && guard_ok && hit(idx, scr_pkg::IDX_RESET_CAUSE, aligned)) begin
            state_nxt.code_base = apb_req_in.pwdata[scr_pkg::CAUSE_CODE_OFS];
        end
        if (wr_acc && guard_ok && hit(idx, scr_pkg::IDX_RESET_CTRL, aligned)) begin
            state_nxt.wdog_rst_en = apb_req_in.pwdata[scr_pkg::CTRL_WDOG_RST_BIT];
        end

        // reset events, strongest first; the code base bit is cleared only by a global reset
        if (reset_evt_in.shutdown_wake_global_reset) begin
            state_nxt           = warm(state_nxt, 1'b0);
            state_nxt.code_base = 1'b0;
            state_nxt.cause     = scr_pkg::CAUSE_SHUTDOWN_WAKE_GLOBAL_RESET;
        end else if (reset_evt_in.manual_pin_reset) begin
            state_nxt       = warm(state_nxt, 1'b0);
            state_nxt.cause = scr_pkg::CAUSE_MR;
        end else if (wdog_ovf && state_r.wdog_rst_en) begin
            state_nxt             = warm(state_nxt, 1'b0);
            state_nxt.cause       = scr_pkg::CAUSE_WTR;
            state_nxt.sys_rst_req = 1'b1;
        end else if (sw_req) begin
            state_nxt             = warm(state_nxt, 1'b0);
            state_nxt.sys_rst_req = 1'b1;
            if (!state_r.wdog_rst_en) begin
                state_nxt.cause = scr_pkg::CAUSE_SR;
            end
        end else if (reset_evt_in.sleep_wake_local_reset) begin
            state_nxt = warm(state_nxt, 1'b1);
            if (state_r.cause == scr_pkg::CAUSE_SR || state_r.cause == scr_pkg::CAUSE_WTR
                || state_r.cause == scr_pkg::CAUSE_MR) begin
                state_nxt.cause = state_r.cause | scr_pkg::CAUSE_LRW;
            end
        end

        // read data is captured in the setup cycle so prdata leaves a flip-flop
        if (rd_setup) begin
            state_nxt.rdata  = 32'h0000_0000;
            state_nxt.slverr = 1'b0;
            if (hit(idx, scr_pkg::IDX_UNLOCK_KEY, aligned)) begin
                state_nxt.rdata[scr_pkg::KEY_TIMER_LSB +: 3] = state_r.win_cnt[3:1];
                state_nxt.rdata[scr_pkg::KEY_ACT_BIT]        = guard_ok;
                state_nxt.rdata[1:0]                         = state_r.unlock;
            end else if (hit(idx, scr_pkg::IDX_CHIP_ID, aligned)) begin
                state_nxt.rdata[7:0] = CHIP_ID_CODE;
            end else if (hit(idx, scr_pkg::IDX_UNLOCK_ID, aligned)) begin
                state_nxt.rdata[7:0] = UNLOCK_ID_CODE;
            end else if (hit(idx, scr_pkg::IDX_WDOG_COUNT, aligned)) begin
                state_nxt.rdata[7:0] = state_r.wdog_cnt;
            end else if (hit(idx, scr_pkg::IDX_RESET_CAUSE, aligned)) begin
                state_nxt.rdata[scr_pkg::CAUSE_CODE_OFS] = state_r.code_base;
                state_nxt.rdata[2:0]                     = state_r.cause;
            end else if (hit(idx, scr_pkg::IDX_BOOT_CFG, aligned)) begin
                state_nxt.rdata[7:6]                        = scr_pkg::CFG_RSVD_HI;
                state_nxt.rdata[scr_pkg::CFG_BOOT_BIT]      = state_r.strap_s.in_boot_program;
                state_nxt.rdata[scr_pkg::CFG_DEBUG_BIT]     = state_r.strap_s.debug_port_enabled;
                state_nxt.rdata[scr_pkg::CFG_BOOT_EN_BIT]   = state_r.strap_s.boot_program_enabled;
                state_nxt.rdata[scr_pkg::CFG_MRST_EN_BIT]   =
                    state_r.strap_s.manual_reset_pin_enabled;
                state_nxt.rdata[scr_pkg::CFG_ROM_READ_BIT]  = state_r.strap_s.flash_readout_allowed;
            end else if (hit(idx, scr_pkg::IDX_RESET_CTRL, aligned)) begin
                state_nxt.rdata[scr_pkg::CTRL_WDOG_RST_BIT] = state_r.wdog_rst_en;
            end else begin
                state_nxt.slverr = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= scr_pkg::STATE_RST;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign apb_rsp_out.prdata   = state_r.rdata;
    assign apb_rsp_out.pready   = 1'b1;
    assign apb_rsp_out.pslverr  = state_r.slverr && apb_req_in.psel && apb_req_in.penable;
    assign unlocked_out         = guard_ok;
    assign code_base_select_out = state_r.code_base;
    assign last_reset_cause_out = state_r.cause;
    assign sys_reset_req_out    = state_r.sys_rst_req;

    // checks
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n);

    logic any_evt;
    assign any_evt = reset_evt_in.manual_pin_reset || reset_evt_in.shutdown_wake_global_reset
                     || reset_evt_in.sleep_wake_local_reset || (wdog_ovf && state_r.wdog_rst_en) || sw_req;

    sequence s_key_first;
        key_wr && state_r.unlock == scr_pkg::UNL_LOCKED && apb_req_in.pwdata[7:0] == scr_pkg::KEY_FIRST
        && !any_evt;
    endsequence
    sequence s_key_second;
        key_wr && apb_req_in.pwdata[7:0] == scr_pkg::KEY_SECOND && !any_evt;
    endsequence

    // a sleep wake that no stronger reset overrides
    sequence s_sleep_only;
        reset_evt_in.sleep_wake_local_reset && !reset_evt_in.manual_pin_reset
        && !reset_evt_in.shutdown_wake_global_reset && !sw_req && !(wdog_ovf && state_r.wdog_rst_en);
    endsequence

    // the bus leaves one idle and one setup cycle between the two key accesses
    a_unlock_pair: assert property (s_key_first ##1 (!key_wr && !any_evt)[*2] ##1 s_key_second
        |=> unlocked_out)
        else $error("key pair did not unlock");
    a_window_close: assert property ($rose(unlocked_out) |-> ##[1:16] !unlocked_out)
        else $error("unlock window stayed open too long");
    a_window_hold: assert property ($rose(unlocked_out) && !any_evt ##1 (!key_wr && !any_evt)[*8]
        |-> unlocked_out)
        else $error("unlock window closed early");
    a_abort_write: assert property (unlocked_out && key_wr |=> !unlocked_out)
        else $error("key write did not close the window");
    a_guard_locked: assert property (!unlocked_out && !any_evt
        |=> $stable(state_r.code_base) && $stable(state_r.wdog_rst_en))
        else $error("guarded register changed while locked");
    a_key_readback: assert property (rd_setup && hit(idx, scr_pkg::IDX_UNLOCK_KEY, aligned)
        |=> apb_rsp_out.prdata[3] == (apb_rsp_out.prdata[1:0] == 2'b11)
            && apb_rsp_out.prdata[6:4] == $past(state_r.win_cnt[3:1]))
        else $error("unlock key readback wrong");
    a_chip_read: assert property (rd_setup && hit(idx, scr_pkg::IDX_CHIP_ID, aligned)
        |=> apb_rsp_out.prdata == {24'h000000, CHIP_ID_CODE})
        else $error("chip identity readback wrong");
    a_unlock_id: assert property (rd_setup && hit(idx, scr_pkg::IDX_UNLOCK_ID, aligned)
        |=> apb_rsp_out.prdata == {24'h000000, UNLOCK_ID_CODE})
        else $error("unlock identity readback wrong");
    a_cfg_read: assert property (rd_setup && hit(idx, scr_pkg::IDX_BOOT_CFG, aligned)
        |=> apb_rsp_out.prdata[31:6] == 26'h0000003 && apb_rsp_out.prdata[1] == 1'b0
            && {apb_rsp_out.prdata[5:2], apb_rsp_out.prdata[0]} == $past(state_r.strap_s))
        else $error("boot configuration readback wrong");
    a_cause_read: assert property (rd_setup && hit(idx, scr_pkg::IDX_RESET_CAUSE, aligned)
        |=> apb_rsp_out.prdata == {27'h0000000, $past(state_r.code_base), 1'b0, $past(state_r.cause)})
        else $error("reset cause readback wrong");
    a_partial_drop: assert property (key_wr && state_r.unlock == scr_pkg::UNL_KEY1 && !any_evt
        && apb_req_in.pwdata[7:0] != scr_pkg::KEY_SECOND && apb_req_in.pwdata[7:0] != scr_pkg::KEY_FIRST
        |=> state_r.unlock == scr_pkg::UNL_LOCKED)
        else $error("stray key write kept the first step");
    a_wdog_wrap: assert property (wdog_ovf && !any_evt |=> state_r.wdog_cnt == 8'h00)
        else $error("watchdog did not wrap");
    a_wdog_rate: assert property (!wdog_tick && !wr_acc && !any_evt |=> $stable(state_r.wdog_cnt))
        else $error("watchdog advanced without a tick");
    a_wdog_reset: assert property (wdog_ovf && state_r.wdog_rst_en && !reset_evt_in.manual_pin_reset
        && !reset_evt_in.shutdown_wake_global_reset
        |=> last_reset_cause_out == scr_pkg::CAUSE_WTR && sys_reset_req_out && state_r.wdog_cnt == 8'h00)
        else $error("watchdog overflow did not reset");
    a_base_keep: assert property (reset_evt_in.manual_pin_reset
        && !reset_evt_in.shutdown_wake_global_reset && !(wr_acc && hit(idx, scr_pkg::IDX_RESET_CAUSE, aligned))
        |=> $stable(state_r.code_base) && state_r.cause == scr_pkg::CAUSE_MR)
        else $error("manual reset cleared the code base bit");
    a_base_global: assert property (reset_evt_in.shutdown_wake_global_reset
        |=> !code_base_select_out && last_reset_cause_out == scr_pkg::CAUSE_SHUTDOWN_WAKE_GLOBAL_RESET)
        else $error("shutdown wake did not clear the code base bit");
    a_sw_record: assert property (sw_req && !state_r.wdog_rst_en && !reset_evt_in.manual_pin_reset
        && !reset_evt_in.shutdown_wake_global_reset
        |=> last_reset_cause_out == scr_pkg::CAUSE_SR && sys_reset_req_out)
        else $error("software reset not recorded");
    a_sw_cause: assert property (sw_req && state_r.wdog_rst_en && !reset_evt_in.manual_pin_reset
        && !reset_evt_in.shutdown_wake_global_reset && !wdog_ovf
        |=> $stable(state_r.cause) && sys_reset_req_out)
        else $error("software reset changed cause with watchdog reset enabled");
    a_sleep_cause: assert property (s_sleep_only ##0 (state_r.cause == scr_pkg::CAUSE_SR
        || state_r.cause == scr_pkg::CAUSE_WTR || state_r.cause == scr_pkg::CAUSE_MR)
        |=> state_r.cause[2] && state_r.cause[1:0] == $past(state_r.cause[1:0]))
        else $error("sleep wake cause not recorded");
    a_sleep_keep: assert property (s_sleep_only ##0 !wr_acc
        |=> $stable(state_r.code_base) && $stable(state_r.wdog_rst_en) && !unlocked_out
            && state_r.wdog_cnt == 8'h00)
        else $error("sleep wake touched retained state");

endmodule

// >>> bench/tb_system_control_regs.sv
// self-checking bench of the system control register block, driven over apb
`timescale 1ns/10ps
module tb_system_control_regs;
    localparam logic [11:0] KEY  = scr_pkg::IDX_UNLOCK_KEY;
    localparam logic [11:0] CAU  = scr_pkg::IDX_RESET_CAUSE;
    localparam logic [11:0] CTRL = scr_pkg::IDX_RESET_CTRL;
    localparam logic [11:0] WDG  = scr_pkg::IDX_WDOG_COUNT;
    logic                    sys_clk_in;
    logic                    rst_n_in;
    scr_pkg::scr_apb_req_t   req;
    scr_pkg::scr_apb_rsp_t   rsp;
    scr_pkg::scr_reset_evt_t evt;
    scr_pkg::scr_straps_t    straps;
    logic                    unl;
    logic                    cbs;
    logic                    rreq;
    logic [2:0]              cause_o;
    logic [31:0]             rd;
    logic                    se;
    logic [7:0]              p;
    int                      err_total = 0;
    int                      compares = 0;
    int                      req_cnt = 0;
    int                      cb;
    int                      cause;
    int                      t0;

    // tick shortened to 16 so that wrap and overflow fit in a short run
    scr_system_control_regs #(.WDOG_TICK_CYCLES(16)) scr_system_control_regs_i (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .apb_req_in(req), .apb_rsp_out(rsp),
        .reset_evt_in(evt), .straps_in(straps), .unlocked_out(unl), .code_base_select_out(cbs),
        .last_reset_cause_out(cause_o), .sys_reset_req_out(rreq));

    initial begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) begin
        if (rreq === 1'b1) req_cnt <= req_cnt + 1;
    end

    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
        @(posedge sys_clk_in);
        req <= '{paddr: {idx, 2'b00}, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: {24'h0, wd}};
        @(posedge sys_clk_in);
        req.penable <= 1'b1;
        do begin
            @(posedge sys_clk_in);
        end while (rsp.pready !== 1'b1);
        rd = rsp.prdata;
        se = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask

    task automatic unlock;
        apb(1'b1, KEY, scr_pkg::KEY_FIRST);
        apb(1'b1, KEY, scr_pkg::KEY_SECOND);
    endtask

    task automatic pulse(input int b);
        @(posedge sys_clk_in);
        evt[b] <= 1'b1;
        @(posedge sys_clk_in);
        evt <= '0;
        repeat (3) @(posedge sys_clk_in);
    endtask

    // model state cb and cause against register and both status outputs
    task automatic chk_cause(input string n);
        apb(1'b0, CAU, 8'h00);
        chk(n, rd, {27'h0, cb[0], 1'b0, cause[2:0]});
        chk("cause_out", {29'h0, cause_o}, {29'h0, cause[2:0]});
        chk("code_base_out", {31'h0, cbs}, {31'h0, cb[0]});
        $display("test %s done", n);
    endtask

    initial begin
        rst_n_in = 1'b0;
        req = '0;
        evt = '0;
        straps = scr_pkg::scr_straps_t'(5'($urandom(32'h7149026e)));
        cb = 0;
        cause = 1;
        repeat (2) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (4) @(posedge sys_clk_in);
        apb(1'b1, scr_pkg::IDX_CHIP_ID, 8'hff);
        apb(1'b0, scr_pkg::IDX_CHIP_ID, 8'h00);
        chk("chip_identity", rd, 32'h5a);
        apb(1'b0, scr_pkg::IDX_UNLOCK_ID, 8'h00);
        chk("unlock_identity", rd, 32'h3c);
        apb(1'b0, KEY, 8'h00);
        chk("unlock_key_reset", rd, 32'h0);
        apb(1'b0, scr_pkg::IDX_BOOT_CFG, 8'h00);
        chk("boot_config", rd, {24'h0, 2'b11, straps[4:1], 1'b0, straps[0]});
        apb(1'b0, 12'h050, 8'h00);
        chk("unmapped_err", {31'h0, se}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        $display("test identity_and_map done");
        chk_cause("reset_values");
        // timer read twice 8 cycles apart must move by 4 whatever the phase
        unlock;
        apb(1'b0, KEY, 8'h00);
        t0 = rd[6:4];
        chk("unlock_open", {rd[31:7], rd[3:0]}, 32'hb);
        repeat (5) @(posedge sys_clk_in);
        apb(1'b0, KEY, 8'h00);
        chk("unlock_timer", {29'h0, rd[6:4]}, 32'(t0 + 4));
        chk("unlock_still_open", {rd[31:7], rd[3:0]}, 32'hb);
        repeat (12) @(posedge sys_clk_in);
        chk("unlocked_out", {31'h0, unl}, 32'h0);
        apb(1'b0, KEY, 8'h00);
        chk("unlock_closed", {rd[31:7], rd[3:0]}, 32'h0);
        $display("test unlock_window done");
        unlock;
        apb(1'b1, CAU, 8'h10);
        cb = 1;
        chk_cause("guarded_write");
        repeat (16) @(posedge sys_clk_in);
        apb(1'b1, CAU, 8'h00);
        chk_cause("locked_write");
        unlock;
        apb(1'b1, KEY, 8'h00);
        // the write lands at the access edge; the output shows it straight after that same edge
        @(posedge sys_clk_in);
        chk("abort_key", {31'h0, unl}, 32'h0);
        apb(1'b1, KEY, scr_pkg::KEY_FIRST);
        apb(1'b1, KEY, 8'h12);
        apb(1'b1, KEY, scr_pkg::KEY_SECOND);
        @(posedge sys_clk_in);
        chk("partial_key", {31'h0, unl}, 32'h0);
        apb(1'b1, CAU, 8'h00);
        chk_cause("aborted_unlock");
        for (int i = 0; i < 2; i++) begin
            p = (i == 0) ? 8'($urandom) : 8'hfd;
            apb(1'b1, WDG, p);
            repeat (63) @(posedge sys_clk_in);
            apb(1'b0, WDG, 8'h00);
            chk("watchdog_count", rd, {24'h0, 8'(p + 8'd4)});
        end
        $display("test watchdog_count done");
        pulse(2);
        cause = 3;
        chk_cause("manual_reset");
        pulse(0);
        cause = 7;
        chk_cause("sleep_after_manual");
        t0 = req_cnt;
        unlock;
        apb(1'b1, CTRL, 8'h01);
        repeat (4) @(posedge sys_clk_in);
        cause = 0;
        chk_cause("software_reset");
        pulse(0);
        cause = 4;
        chk_cause("sleep_after_soft");
        unlock;
        apb(1'b1, CTRL, 8'h02);
        apb(1'b1, WDG, 8'hff);
        repeat (20) @(posedge sys_clk_in);
        cause = 2;
        chk_cause("watchdog_reset");
        pulse(0);
        cause = 6;
        chk_cause("sleep_after_wdog");
        pulse(2);
        cause = 3;
        unlock;
        apb(1'b1, CTRL, 8'h02);
        unlock;
        apb(1'b1, CTRL, 8'h03);
        repeat (4) @(posedge sys_clk_in);
        chk_cause("soft_with_wdog_en");
        chk("reset_requests", 32'(req_cnt - t0), 32'd3);
        pulse(1);
        cause = 5;
        cb = 0;
        chk_cause("shutdown_wake");
        stop_test;
    end

    // the run needs about four hundred cycles; five thousand means a hang
    initial begin
        repeat (5000) @(posedge sys_clk_in);
        err_total++;
        stop_test;
    end
endmodule
